// file: spwm_chk_sva.sv
module spwm_chk_sva #(
    parameter int unsigned OSC_PERIOD = 1000
)(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic controlLevelCmp_n,
    input wire logic onPulse,
    input wire logic offPulse,
    input wire logic fetDrive,
    input wire logic inrushBypass,
    input wire logic dropoutOk,
    input wire logic powerOnClear_n,
    input wire logic overvoltageTrip
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    int unsigned gap;
    // Saturates so a long idle spell cannot wrap into a false short gap
    always_ff @(posedge clk_sys) gap <= rst ? OSC_PERIOD : $rose(onPulse) ? 1 : gap + 32'(gap < OSC_PERIOD);
    sequence s_two(s); s ##1 !s; endsequence
    property p_onw; $rose(onPulse) |=> s_two(onPulse); endproperty
    a_onw: assert property (p_onw) else $error("on width");
    property p_offw; $rose(offPulse) |=> s_two(offPulse); endproperty
    a_offw: assert property (p_offw) else $error("off width");
    property p_onfet; $rose(onPulse) |-> powerOnClear_n ##[0:1] fetDrive; endproperty
    a_onfet: assert property (p_onfet) else $error("on gate");
    property p_offfet; $rose(offPulse) |=> !fetDrive; endproperty
    a_offfet: assert property (p_offfet) else $error("off gate");
    property p_cv; $fell(controlLevelCmp_n) && fetDrive |-> ##[0:8] offPulse; endproperty
    a_cv: assert property (p_cv) else $error("cv end");
    property p_per; $rose(onPulse) |-> gap >= OSC_PERIOD; endproperty
    a_per: assert property (p_per) else $error("period");
    property p_byp; !powerOnClear_n |=> !dropoutOk && !inrushBypass; endproperty
    a_byp: assert property (p_byp) else $error("bypass");
    property p_trip; overvoltageTrip && powerOnClear_n |=> overvoltageTrip; endproperty
    a_trip: assert property (p_trip) else $error("trip hold");
endmodule : spwm_chk_sva

bind spwm_core spwm_chk_sva #(.OSC_PERIOD(OSC_PERIOD)) chk (.*);

// file: spwm_core.sv
// Notes on behaviour
// - Control level comparator low ends on period
// - Power cap comparator low disables modulator
// - Every return from on to reset fires the off-pulse
// - Oscillator holds reset 1.5us, then sets output
// - Modulator rising fires the on-pulse one-shot
// - Enable, voltage and current loops also disable
// - Active from on-pulse until off-pulse issued
// - 20kHz switching; four off-pulse causes
// - FET drive follows on and off pulses
// - Bias detector holds modulator, delay and trip latch in reset
// - Three second delay then bypass inrush, enable
// - Discharge unit on mains loss, shutdown, lower demand
// - Delay counts 1.25kHz ticks while detector, clear high
// - 20ms without mains pulse inhibits, discharges
// - Overvoltage trip latches until power-on clear
module spwm_core
    import spwm_pkg::*;
#(
    parameter int unsigned OSC_PERIOD  = OSC_CYC,
    parameter int unsigned DLY_PRESC   = DLY_TICK_CYC,
    parameter int unsigned DLY_COUNT   = DLY_TICKS,
    parameter int unsigned MAINS_LIMIT = MAINS_CYC
)(
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic biasGood,
    input  wire logic controlLevelCmp_n,
    input  wire logic powerCapCmp_n,
    input  wire logic masterEnable,
    input  wire logic voltLoopOk,
    input  wire logic currLoopOk,
    input  wire logic shutdown_n,
    input  wire logic mainsPulse,
    input  wire logic overvoltageCmp,
    input  wire logic lowerDemand,
    output logic      onPulse,
    output logic      offPulse,
    output logic      fetDrive,
    output logic      inrushBypass,
    output logic      dropoutOk,
    output logic      dischargeOn,
    output logic      powerOnClear_n,
    output logic      overvoltageTrip
);
    localparam int NS = 8;

    // Sync stages: first rank read only by the second
    logic [NS-1:0] syncA;
    logic [NS-1:0] syncB;
    logic [NS-1:0] rawIn;
    assign rawIn = {biasGood, controlLevelCmp_n, powerCapCmp_n, masterEnable,
                    voltLoopOk, currLoopOk, shutdown_n, mainsPulse};
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            syncA <= '0;
            syncB <= '0;
        end
        else
        begin
            syncA <= rawIn;
            syncB <= syncA;
        end
    end

    logic sBias, sCtl, sCap, sEn, sVl, sCl, sShut, sMains;
    assign {sBias, sCtl, sCap, sEn, sVl, sCl, sShut, sMains} = syncB;

    logic        ovSyncA, next_ovSyncA;
    logic        ovSync, next_ovSync;
    logic        mainsLast, next_mainsLast;
    logic [31:0] mainsCnt, next_mainsCnt;
    logic        mainsLost, next_mainsLost;
    logic [31:0] prescCnt, next_prescCnt;
    logic [31:0] dlyCnt, next_dlyCnt;
    logic        next_dropoutOk, next_inrushBypass;
    logic        next_ovTrip, next_clear_n, next_discharge;

    // Counters share one increment so every width stays 32 bits
    function automatic logic [31:0] bump(input logic [31:0] v);
        return v + 32'h0000_0001;
    endfunction : bump

    function automatic logic [31:0] drain(input logic [31:0] v);
        return (v != '0) ? v - 32'h0000_0001 : '0;
    endfunction : drain

    function automatic logic expired(input logic [31:0] cnt, input int unsigned lim);
        return cnt >= lim - 1;
    endfunction : expired

    // Mains watchdog: counted as lost until the first pulse edge after reset
    always_comb
    begin
        next_mainsLast = sMains;
        next_mainsCnt = mainsCnt;
        next_mainsLost = mainsLost;
        if (sMains && !mainsLast)
        begin
            next_mainsCnt = '0;
            next_mainsLost = 1'b0;
        end
        else if (expired(mainsCnt, MAINS_LIMIT))
            next_mainsLost = 1'b1;
        else
            next_mainsCnt = bump(mainsCnt);
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            mainsLast <= 1'b0;
            mainsCnt <= '0;
            mainsLost <= 1'b1;
        end
        else
        begin
            mainsLast <= next_mainsLast;
            mainsCnt <= next_mainsCnt;
            mainsLost <= next_mainsLost;
        end
    end

    // Startup delay restarts in full after any clear or dropout
    always_comb
    begin
        next_prescCnt = prescCnt;
        next_dlyCnt = dlyCnt;
        next_dropoutOk = dropoutOk;
        if (!powerOnClear_n || mainsLost)
        begin
            next_prescCnt = '0;
            next_dlyCnt = '0;
            next_dropoutOk = 1'b0;
        end
        else if (!dropoutOk)
        begin
            if (expired(prescCnt, DLY_PRESC))
            begin
                next_prescCnt = '0;
                next_dlyCnt = bump(dlyCnt);
                if (expired(dlyCnt, DLY_COUNT))
                    next_dropoutOk = 1'b1;
            end
            else
                next_prescCnt = bump(prescCnt);
        end
        next_inrushBypass = next_dropoutOk;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            prescCnt <= '0;
            dlyCnt <= '0;
            dropoutOk <= 1'b0;
            inrushBypass <= 1'b0;
        end
        else
        begin
            prescCnt <= next_prescCnt;
            dlyCnt <= next_dlyCnt;
            dropoutOk <= next_dropoutOk;
            inrushBypass <= next_inrushBypass;
        end
    end

    // A clear seen in the same cycle as a trip wins; only the clear empties it
    // Lower demand is a steady level, so it skips the synchronisers
    always_comb
    begin
        next_ovSyncA = overvoltageCmp;
        next_ovSync = ovSyncA;
        next_clear_n = sBias;
        next_ovTrip = overvoltageTrip | ovSync;
        if (!powerOnClear_n)
            next_ovTrip = 1'b0;
        next_discharge = mainsLost | !sShut | next_ovTrip | lowerDemand
                       | !sEn | !powerOnClear_n;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ovSyncA <= 1'b0;
            ovSync <= 1'b0;
            powerOnClear_n <= 1'b0;
            overvoltageTrip <= 1'b0;
            dischargeOn <= 1'b1;
        end
        else
        begin
            ovSyncA <= next_ovSyncA;
            ovSync <= next_ovSync;
            powerOnClear_n <= next_clear_n;
            overvoltageTrip <= next_ovTrip;
            dischargeOn <= next_discharge;
        end
    end

    // Oscillator runs free; its wrap is the switching clock
    logic [31:0] oscCnt, next_oscCnt;
    logic        oscWrap, holdEnd;

    assign oscWrap = expired(oscCnt, OSC_PERIOD);
    assign holdEnd = oscCnt == HOLD_CYC - 1;

    always_comb
    begin
        next_oscCnt = oscWrap ? '0 : bump(oscCnt);
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            oscCnt <= '0;
        else
            oscCnt <= next_oscCnt;
    end

    // Modulator
    spwm_state_t state, next_state;
    logic [31:0] onShot, next_onShot;
    logic [31:0] offShot, next_offShot;
    logic        next_onPulse, next_offPulse, next_fetDrive;
    logic        inhibit, endPeriod;

    // Any inhibit keeps the modulator from ever reaching the on state
    assign inhibit = !sCap || !sEn || !sVl || !sCl || !sShut
                   || !dropoutOk || overvoltageTrip;
    // The oscillator wrap is itself an off cause
    assign endPeriod = !sCtl || inhibit || oscWrap;

    // Arming only at the end of the hold allows one on per period at most
    always_comb
    begin
        next_state = state;
        next_onShot = drain(onShot);
        next_offShot = drain(offShot);
        case (state)
            SPWM_RESET:
            begin
                if (holdEnd && !inhibit)
                    next_state = SPWM_ARMED;
            end
            SPWM_ARMED:
            begin
                if (inhibit)
                    next_state = SPWM_RESET;
                else
                begin
                    next_state = SPWM_ON;
                    next_onShot = SHOT_CYC;
                end
            end
            SPWM_ON:
            begin
                if (endPeriod)
                begin
                    next_state = SPWM_RESET;
                    next_offShot = SHOT_CYC;
                end
            end
            default:
                next_state = SPWM_RESET;
        endcase
        if (!powerOnClear_n)
        begin
            next_state = SPWM_RESET;
            next_onShot = '0;
            if (state == SPWM_ON)
                next_offShot = SHOT_CYC;
        end
        next_onPulse = next_onShot != '0;
        next_offPulse = next_offShot != '0;
        next_fetDrive = next_state == SPWM_ON;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state <= SPWM_RESET;
            onShot <= '0;
            offShot <= '0;
            onPulse <= 1'b0;
            offPulse <= 1'b0;
            fetDrive <= 1'b0;
        end
        else
        begin
            state <= next_state;
            onShot <= next_onShot;
            offShot <= next_offShot;
            onPulse <= next_onPulse;
            offPulse <= next_offPulse;
            fetDrive <= next_fetDrive;
        end
    end
endmodule : spwm_core

// file: spwm_far.sv
module spwm_far (
    input  wire logic       clk_sys,
    input  wire logic       fetDrive,
    input  wire logic [7:0] rampLen,
    input  wire logic       mainsOn,
    output logic            controlLevelCmp_n,
    output logic            mainsPulse
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] ramp = 8'h00;
    logic [5:0] tick = 6'h00;
    // Ramp builds only while FETs conduct; length 0 never reaches the control level
    always @(posedge clk_sys) ramp <= fetDrive ? ramp + 8'h01 : 8'h00;
    always @(posedge clk_sys) tick <= tick + 6'h01;
    assign controlLevelCmp_n = rampLen == 8'h00 || ramp < rampLen;
    assign mainsPulse = mainsOn & tick[5];
endmodule : spwm_far

// file: spwm_pkg.sv
package spwm_pkg;
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned OSC_HZ          = 20_000;
    localparam int unsigned OSC_CYC         = CLK_HZ / OSC_HZ;
    localparam int unsigned HOLD_NS         = 1_500;
    localparam int unsigned CLK_NS          = 50;
    localparam int unsigned HOLD_CYC        = (HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned DLY_TICK_HZ     = 1_250;
    localparam int unsigned DLY_TICK_CYC    = CLK_HZ / DLY_TICK_HZ;
    localparam int unsigned DLY_SEC         = 3;
    localparam int unsigned DLY_TICKS       = DLY_SEC * DLY_TICK_HZ;
    localparam int unsigned MAINS_MS        = 20;
    localparam int unsigned MAINS_CYC       = MAINS_MS * (CLK_HZ / 1_000);
    localparam int unsigned SHOT_CYC        = 2;

    typedef enum logic [2:0] {
        SPWM_RESET = 3'h1,
        SPWM_ARMED = 3'h2,
        SPWM_ON    = 3'h4
    } spwm_state_t;
endpackage : spwm_pkg

// file: tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int P = 100;
    logic       clk_sys = 1'b0, rst = 1'b1, biasGood = 1'b0, mainsOn = 1'b1, overvoltageCmp = 1'b0;
    logic [5:0] ctl = 6'h1F;
    logic [7:0] rampLen = 8'h0A;
    logic       controlLevelCmp_n, mainsPulse, onPulse, offPulse, fetDrive, inrushBypass, dropoutOk;
    logic       dischargeOn, powerOnClear_n, overvoltageTrip;
    int         bad_count = 0, cmp_count = 0, cyc = 0, k, i;
    spwm_core #(.OSC_PERIOD(P), .DLY_PRESC(4), .DLY_COUNT(5), .MAINS_LIMIT(200)) uut (.*, .lowerDemand(ctl[5]),
        .powerCapCmp_n(ctl[4]), .masterEnable(ctl[3]), .voltLoopOk(ctl[2]), .currLoopOk(ctl[1]), .shutdown_n(ctl[0]));
    spwm_far far (.*);
    always #25 clk_sys = !clk_sys;
    always @(posedge clk_sys) if (++cyc == 9000) tally_and_finish(1);
    task automatic chk(input string nm, input logic e, input logic g);
        cmp_count++;
        bad_count += int'(g !== e);
        if (g !== e) $display("BAD %s exp %b got %b", nm, e, g);
    endtask : chk
    task automatic rise;
        k = 0;
        while (onPulse === 1'b1) @(negedge clk_sys) k++;
        while (onPulse !== 1'b1 && k < 3 * P) @(negedge clk_sys) k++;
    endtask : rise
    task automatic tally_and_finish(input int extra);
        if (bad_count + extra == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    task automatic t_start;
        biasGood = 1'b1;
        repeat (10) @(negedge clk_sys);
        chk("early", 1'b0, dropoutOk);
        rise();
        chk("byp", 1'b1, inrushBypass && k < 3 * P);
    endtask : t_start
    task automatic t_cycle(input logic [7:0] len);
        rampLen = len;
        rise();
        rise();
        chk("per", 1'b1, k == P);
        for (k = 0; k < P && fetDrive === 1'b1; k++) @(negedge clk_sys);
        chk("wid", 1'b1, len ? k >= len && k <= len + 8 : k < P);
        chk("off", 1'b1, offPulse);
    endtask : t_cycle
    task automatic t_inh;
        for (i = 0; i < 6; i++)
        begin
            ctl = 6'h1F ^ (6'h01 << i);
            repeat (6) @(negedge clk_sys);
            rise();
            chk("inh", i < 5, k == 3 * P);
            if (i % 5 == 0) chk("dis", 1'b1, dischargeOn);
        end
        ctl = 6'h1F;
    endtask : t_inh
    task automatic t_ovp;
        overvoltageCmp = 1'b1;
        rise();
        overvoltageCmp = 1'b0;
        chk("trip", 1'b1, overvoltageTrip && dischargeOn && k == 3 * P);
        biasGood = 1'b0;
        repeat (6) @(negedge clk_sys);
        chk("clr", 1'b0, powerOnClear_n || overvoltageTrip);
        biasGood = 1'b1;
        rise();
        chk("restart", 1'b1, k < 3 * P);
        mainsOn = 1'b0;
        repeat (250) @(negedge clk_sys);
        rise();
        chk("mains", 1'b1, dischargeOn && k == 3 * P);
    endtask : t_ovp
    initial
    begin
        repeat (6) @(negedge clk_sys);
        rst = 1'b0;
        t_start();
        t_cycle(8'h0A);
        t_cycle(8'h00);
        t_inh();
        t_ovp();
        tally_and_finish(0);
    end
endmodule : tb_top
